/* design/cpg_defs.svh */
// Offsets, field positions, reset values and codes of the clock pulse generator
`ifndef CPG_DEFS_SVH
`define CPG_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define CPG_OFF_SBY        8'h00
`define CPG_OFF_LPW        8'h04
`define CPG_OFF_MSH        8'h08
`define CPG_OFF_MSL        8'h0c
`define CPG_OFF_STC        8'h10
`define CPG_OFF_MODE       8'h14
`define CPG_OFF_STAT       8'h18

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CPG_SBY_SSBY       7
`define CPG_SBY_STS_MSB    6
`define CPG_SBY_STS_LSB    4
`define CPG_SBY_SCK_MSB    2
`define CPG_SBY_SCK_LSB    0
`define CPG_LPW_SUBCLOCK_INPUT_ENABLE      7
`define CPG_LPW_NOISE_SAMPLE_RATE_SELECT      6
`define CPG_STC_FLWIN      3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CPG_RST_SBY        8'h00
`define CPG_RST_LPW        8'h00
`define CPG_RST_MST        8'h00
`define CPG_RST_STC        8'h00

// ----------------------------------------------------------------------------
// Bus clock select codes and divider
// ----------------------------------------------------------------------------
`define CPG_SCK_FULL       3'h0
`define CPG_SCK_DIV32      3'h5
`define CPG_DIV_W          5
`define CPG_DIV_WRAP       5'h1f
`define CPG_SAMP_FAST_MASK 5'h03
`define CPG_SAMP_SLOW_MASK 5'h1f

// ----------------------------------------------------------------------------
// Mode request codes
// ----------------------------------------------------------------------------
`define CPG_REQ_RUN        3'h0
`define CPG_REQ_SLEEP      3'h1
`define CPG_REQ_SUBACT     3'h2
`define CPG_REQ_SUBSLEEP   3'h3
`define CPG_REQ_WATCH      3'h4
`define CPG_REQ_SWSTBY     3'h5

// ----------------------------------------------------------------------------
// Duty correction lower bound and oscillator frequency
// ----------------------------------------------------------------------------
`define CPG_DUTY_MIN_KHZ   5000
`define CPG_OSC_KHZ        20000

`endif

/* design/cpg_pkg.sv */
// Types shared by the clock pulse generator
package cpg_pkg;
    typedef enum logic [6:0] {
        CPG_RUN      = 7'b0000001,
        CPG_SLEEP    = 7'b0000010,
        CPG_SUBACT   = 7'b0000100,
        CPG_SUBSLEEP = 7'b0001000,
        CPG_WATCH    = 7'b0010000,
        CPG_SWSTBY   = 7'b0100000,
        CPG_HWSTBY   = 7'b1000000
    } cpg_mode_t;
    typedef logic [2:0] cpg_sck_t;
endpackage

/* design/cpg_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module cpg_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

/* design/cpg_top.sv */
// Clock pulse generator: dividers, bus clock select, subclock, power-down gating
// What this block is required to do
// RQ1: Duty correction only at 5 MHz or above
// RQ2: Divide system clock by 2,4,8,16,32
// RQ3: Bus master gets full or divided clock
// RQ4: Select code 000 full, 001-101 dividers
// RQ5: Select cleared before subactive or watch entry
// RQ6: Subclock needs pin input and enable
// RQ7: Keep subclock enable cleared when unused
// RQ8: Two subclock periods before power-down entry; mode_q changes on the mode write, with no wait
// RQ9: Noise-sample subclock at selectable divided rate
// RQ10: No subclock sampling in sub modes
// RQ11: Main oscillator clock in run and sleep
// RQ12: Subclock is system clock in sub modes
// RQ13: Timer clocks divide subclock-based system clock
// RQ14: Subactive runs CPU, timers, watchdogs only
// RQ15: Sleep stops CPU, peripherals keep running
// RQ16: Subsleep keeps only timers and watchdogs
// RQ17: Watch keeps only second watchdog
// RQ18: Software standby halts oscillator and everything
// RQ19: Hardware standby halts oscillator, resets everything
// RQ20: Module stop bits stop single peripherals
// RQ21: Power registers reachable only with window cleared
// RQ22: Glitch-free bus clock and source switching
`timescale 1ns/100ps
`include "cpg_defs.svh"
module cpg_top
    import cpg_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        subclock_pin,
    input  wire logic        hw_standby_n_pin,
    input  wire logic        wake_pin,
    output logic             duty_corr_en,
    output logic             osc_run,
    output logic             sys_clk_en,
    output logic [4:0]       med_clk_en,
    output logic             bus_clk_en,
    output logic             cpu_clk_en,
    output logic [15:0]      periph_clk_en,
    output logic             tmr_a_clk_en,
    output logic             tmr_b_clk_en,
    output logic             wdt_a_clk_en,
    output logic             wdt_b_clk_en,
    output logic             cpu_rst_n,
    output logic             periph_rst_n
);
    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    cpg_mode_t              mode_q;
    logic [7:0]             sby_q;
    logic [7:0]             lpw_q;
    logic [7:0]             msh_q;
    logic [7:0]             msl_q;
    logic [7:0]             stc_q;
    cpg_sck_t               sck_act_q;
    logic [`CPG_DIV_W-1:0]  div_q;
    logic                   sub_filt_q;
    logic                   sub_samp_q;
    logic                   sub_prev_q;
    logic [2:0]             pins_s;
    logic                   sub_s;
    logic                   hwstby_n_s;
    logic                   wake_s;
    logic                   sub_mode;
    logic                   phi_en;
    logic                   sub_tick;
    logic                   samp_en;
    logic [4:0]             med_en;
    logic                   bus_en;
    logic                   wr_en;
    logic                   rd_en;
    logic                   pwr_sel;
    logic                   hit;
    logic                   win_ok;
    logic [31:0]            rdata_d;
    logic [2:0]             req;
    logic                   osc_on;

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    cpg_sync #(.W(3)) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     ({subclock_pin, hw_standby_n_pin, wake_pin}),
        .q     (pins_s)
    );
    assign sub_s      = pins_s[2];
    assign hwstby_n_s = pins_s[1];
    assign wake_s     = pins_s[0];

    // ------------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------------
    // Zero wait states; errors on unmapped or locked-out power registers
    assign pwr_sel = (paddr == `CPG_OFF_SBY) || (paddr == `CPG_OFF_LPW) ||
                     (paddr == `CPG_OFF_MSH) || (paddr == `CPG_OFF_MSL);
    assign win_ok  = !stc_q[`CPG_STC_FLWIN];
    assign hit     = (pwr_sel && win_ok) || (paddr == `CPG_OFF_STC) ||
                     (paddr == `CPG_OFF_MODE) || (paddr == `CPG_OFF_STAT);  // [RQ21]
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign wr_en   = psel && penable && pwrite && hit;
    assign rd_en   = psel && !penable && !pwrite;
    assign req     = pwdata[2:0];

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (pwr_sel && !win_ok) begin
            rdata_d = 32'h0000_0000;                                      // [RQ21]
        end else begin
            unique case (paddr)
                `CPG_OFF_SBY:  rdata_d[7:0] = {sby_q[7:4], 1'b0, sby_q[2:0]};
                `CPG_OFF_LPW:  rdata_d[7:0] = lpw_q;
                `CPG_OFF_MSH:  rdata_d[7:0] = msh_q;
                `CPG_OFF_MSL:  rdata_d[7:0] = msl_q;
                `CPG_OFF_STC:  rdata_d[7:0] = stc_q;
                `CPG_OFF_STAT: rdata_d[10:0] = {duty_corr_en, sck_act_q, mode_q};
                default:       rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= rdata_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sby_q <= `CPG_RST_SBY;
            lpw_q <= `CPG_RST_LPW;
            msh_q <= `CPG_RST_MST;
            msl_q <= `CPG_RST_MST;
            stc_q <= `CPG_RST_STC;
        end else if (wr_en) begin
            unique case (paddr)
                `CPG_OFF_SBY: sby_q <= {pwdata[7:4], 1'b0, pwdata[2:0]};
                `CPG_OFF_LPW: lpw_q <= {pwdata[7:6], 6'h00};
                `CPG_OFF_MSH: msh_q <= pwdata[7:0];
                `CPG_OFF_MSL: msl_q <= pwdata[7:0];
                `CPG_OFF_STC: stc_q <= {4'h0, pwdata[3], 3'h0};
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Operating mode
    // ------------------------------------------------------------------------
    // Subactive and watch refused unless full-rate bus clock and subclock enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= CPG_RUN;                                            // [RQ11]
        end else if (!hwstby_n_s) begin
            mode_q <= CPG_HWSTBY;                                         // [RQ19]
        end else begin
            unique case (mode_q)
                CPG_RUN, CPG_SUBACT: begin
                    if (wr_en && paddr == `CPG_OFF_MODE) begin
                        if (req == `CPG_REQ_SLEEP && mode_q == CPG_RUN) begin
                            mode_q <= CPG_SLEEP;
                        end else if (req == `CPG_REQ_SWSTBY && mode_q == CPG_RUN) begin
                            mode_q <= CPG_SWSTBY;
                        end else if (req == `CPG_REQ_RUN) begin
                            mode_q <= CPG_RUN;
                        end else if (req == `CPG_REQ_SUBSLEEP && mode_q == CPG_SUBACT) begin
                            mode_q <= CPG_SUBSLEEP;
                        end else if ((req == `CPG_REQ_SUBACT || req == `CPG_REQ_WATCH) &&
                                     sby_q[`CPG_SBY_SCK_MSB:`CPG_SBY_SCK_LSB] == `CPG_SCK_FULL &&
                                     lpw_q[`CPG_LPW_SUBCLOCK_INPUT_ENABLE]) begin         // [RQ5] [RQ6]
                            mode_q <= (req == `CPG_REQ_WATCH) ? CPG_WATCH : CPG_SUBACT;
                        end
                    end
                end
                CPG_SLEEP, CPG_SWSTBY, CPG_WATCH, CPG_HWSTBY: begin
                    if (wake_s || mode_q == CPG_HWSTBY) begin
                        mode_q <= CPG_RUN;                                // [RQ11]
                    end
                end
                CPG_SUBSLEEP: begin
                    if (wake_s) begin
                        mode_q <= CPG_SUBACT;
                    end
                end
            endcase
        end
    end

    assign sub_mode = (mode_q == CPG_SUBACT) || (mode_q == CPG_SUBSLEEP) ||
                      (mode_q == CPG_WATCH);

    // ------------------------------------------------------------------------
    // Subclock conditioning
    // ------------------------------------------------------------------------
    // Outside sub modes two matching samples needed; a single noisy sample is dropped
    assign samp_en = (lpw_q[`CPG_LPW_NOISE_SAMPLE_RATE_SELECT] ?
                      ((div_q & `CPG_SAMP_FAST_MASK) == `CPG_SAMP_FAST_MASK) :
                      ((div_q & `CPG_SAMP_SLOW_MASK) == `CPG_SAMP_SLOW_MASK)) && phi_en;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_samp_q <= 1'b0;
            sub_filt_q <= 1'b0;
        end else if (!lpw_q[`CPG_LPW_SUBCLOCK_INPUT_ENABLE]) begin
            sub_samp_q <= 1'b0;
            sub_filt_q <= 1'b0;
        end else if (sub_mode) begin
            sub_filt_q <= sub_s;                                          // [RQ10]
        end else if (samp_en) begin
            sub_samp_q <= sub_s;                                          // [RQ9]
            if (sub_samp_q == sub_s) begin
                sub_filt_q <= sub_s;                                      // [RQ9]
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_prev_q <= 1'b0;
        end else begin
            sub_prev_q <= sub_filt_q;
        end
    end

    assign sub_tick = sub_filt_q && !sub_prev_q;

    // ------------------------------------------------------------------------
    // System clock and dividers
    // ------------------------------------------------------------------------
    // Source follows the mode register, so it changes only between ticks
    // A net, not a function, so every mode change re-evaluates the source
    assign osc_on = (mode_q != CPG_SWSTBY) && (mode_q != CPG_HWSTBY);    // [RQ18] [RQ19]
    assign phi_en = sub_mode ? sub_tick : osc_on;                         // [RQ11] [RQ12] [RQ22]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= '0;
        end else if (phi_en) begin
            div_q <= div_q + 5'h01;                                       // [RQ2]
        end
    end

    generate
        for (genvar k = 0; k < 5; k++) begin : g_med
            assign med_en[k] = phi_en && (div_q[k:0] == {(k+1){1'b1}});   // [RQ2] [RQ13]
        end
    endgenerate

    // New select takes effect only where every divided phase ends together
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_act_q <= `CPG_SCK_FULL;
        end else if (phi_en && div_q == `CPG_DIV_WRAP &&
                     sby_q[`CPG_SBY_SCK_MSB:`CPG_SBY_SCK_LSB] <= `CPG_SCK_DIV32) begin
            sck_act_q <= sby_q[`CPG_SBY_SCK_MSB:`CPG_SBY_SCK_LSB];       // [RQ22] [RQ4]
        end
    end

    always_comb begin
        bus_en = phi_en;
        if (sck_act_q != `CPG_SCK_FULL) begin
            bus_en = med_en[sck_act_q - 3'h1];                            // [RQ3] [RQ4]
        end
    end

    // ------------------------------------------------------------------------
    // Output gating (registered, one cycle after the tick)
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_corr_en  <= 1'b0;
            osc_run       <= 1'b0;
            sys_clk_en    <= 1'b0;
            med_clk_en    <= 5'h00;
            bus_clk_en    <= 1'b0;
            cpu_clk_en    <= 1'b0;
            periph_clk_en <= 16'h0000;
            tmr_a_clk_en  <= 1'b0;
            tmr_b_clk_en  <= 1'b0;
            wdt_a_clk_en  <= 1'b0;
            wdt_b_clk_en  <= 1'b0;
            cpu_rst_n     <= 1'b0;
            periph_rst_n  <= 1'b0;
        end else begin
            duty_corr_en  <= osc_on && !sub_mode &&
                             (`CPG_OSC_KHZ >= `CPG_DUTY_MIN_KHZ);         // [RQ1]
            osc_run       <= osc_on;                                      // [RQ18]
            sys_clk_en    <= phi_en;
            med_clk_en    <= med_en;                                      // [RQ13]
            bus_clk_en    <= bus_en && (mode_q == CPG_RUN || mode_q == CPG_SUBACT);
            cpu_clk_en    <= phi_en && (mode_q == CPG_RUN ||
                                        mode_q == CPG_SUBACT);            // [RQ14] [RQ15]
            periph_clk_en <= {16{phi_en && (mode_q == CPG_RUN || mode_q == CPG_SLEEP)}}
                             & ~{msh_q, msl_q};                           // [RQ15] [RQ20]
            tmr_a_clk_en  <= phi_en && !(mode_q == CPG_WATCH);            // [RQ16] [RQ17]
            tmr_b_clk_en  <= phi_en && !(mode_q == CPG_WATCH);            // [RQ14] [RQ16]
            wdt_a_clk_en  <= phi_en && !(mode_q == CPG_WATCH);            // [RQ14] [RQ17]
            wdt_b_clk_en  <= phi_en;                                      // [RQ17]
            cpu_rst_n     <= (mode_q != CPG_HWSTBY);                      // [RQ19]
            periph_rst_n  <= (mode_q != CPG_HWSTBY);                      // [RQ19]
        end
    end
endmodule

/* verification/cpg_subclk_src.sv */
// Behavioural external subclock source
`timescale 1ns/100ps
module cpg_subclk_src #(
    parameter int HALF = 305
) (
    input  wire logic pclk,
    input  wire logic en,
    output logic      subclk
);
    int   ph_q  = 0;
    logic clk_q = 1'b0;
    assign subclk = clk_q;
    // Counted in pclk so tick counts per window are exact; 305 is the nearest half period
    always @(posedge pclk) begin
        if (!en) begin
            ph_q  <= 0;
            clk_q <= 1'b0;
        end else if (ph_q == HALF - 1) begin
            ph_q  <= 0;
            clk_q <= ~clk_q;
        end else begin
            ph_q <= ph_q + 1;
        end
    end
endmodule

/* verification/cpg_top_props.sv */
// Port-level assertions of the clock pulse generator
`timescale 1ns/100ps
module cpg_top_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pslverr,
    input wire logic        duty_corr_en,
    input wire logic        osc_run,
    input wire logic        sys_clk_en,
    input wire logic [4:0]  med_clk_en,
    input wire logic        bus_clk_en,
    input wire logic        cpu_clk_en,
    input wire logic [15:0] periph_clk_en,
    input wire logic        tmr_a_clk_en,
    input wire logic        tmr_b_clk_en,
    input wire logic        wdt_a_clk_en,
    input wire logic        wdt_b_clk_en,
    input wire logic        periph_rst_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_err_only_access: assert property (pslverr |-> psel && penable)
        else $error("error flag outside access phase");
    a_unmapped_err: assert property (psel && penable && paddr > 8'h18 |-> pslverr)
        else $error("unmapped access not refused");
    a_med_half_rate: assert property (med_clk_en[0] |=> !med_clk_en[0])
        else $error("half rate tick on two cycles in a row");
    a_med_on_tick: assert property (med_clk_en[4] |-> med_clk_en[3] && sys_clk_en)
        else $error("divided tick without system tick");
    a_bus_on_tick: assert property (bus_clk_en |-> sys_clk_en)
        else $error("bus tick without system tick");
    a_standby_no_tick: assert property (!osc_run && $past(!osc_run) |-> !sys_clk_en)
        else $error("system tick while oscillator halted");
    a_hwsb_osc_off: assert property (!periph_rst_n && $past(!periph_rst_n) |-> !osc_run)
        else $error("oscillator runs while peripherals in reset");
    a_wdtb_always: assert property (sys_clk_en |-> wdt_b_clk_en)
        else $error("second watchdog missed a tick");
    a_timer_group: assert property (tmr_a_clk_en |-> tmr_b_clk_en && wdt_a_clk_en)
        else $error("timer group ticks apart");
    a_cpu_with_tmr: assert property (cpu_clk_en |-> tmr_a_clk_en)
        else $error("cpu tick without timer tick");
    a_periph_tmr: assert property (|periph_clk_en |-> tmr_a_clk_en && sys_clk_en)
        else $error("peripheral tick out of place");
    a_duty_osc: assert property (duty_corr_en |-> osc_run)
        else $error("duty correction with oscillator halted");

    c_standby: cover property (!osc_run ##1 osc_run);
    c_sleep: cover property (|periph_clk_en && !cpu_clk_en);
    c_watch: cover property (wdt_b_clk_en && !tmr_a_clk_en);
endmodule

bind cpg_top cpg_top_props cpg_top_props_inst (.pclk, .presetn, .paddr, .psel, .penable,
    .pslverr, .duty_corr_en, .osc_run, .sys_clk_en, .med_clk_en, .bus_clk_en, .cpu_clk_en,
    .periph_clk_en, .tmr_a_clk_en, .tmr_b_clk_en, .wdt_a_clk_en, .wdt_b_clk_en, .periph_rst_n);

/* verification/test_cpg_top.sv */
// Self-checking bench of the clock pulse generator
`timescale 1ns/100ps
`include "cpg_defs.svh"
module test_cpg_top import cpg_pkg::*;;
    logic        pclk, presetn, psel, penable, pwrite, hw_standby_n_pin, wake_pin, sub_en;
    logic        subclock_pin, pready, pslverr, duty_corr_en, osc_run, sys_clk_en;
    logic        bus_clk_en, cpu_clk_en, tmr_a_clk_en, tmr_b_clk_en, wdt_a_clk_en;
    logic        wdt_b_clk_en, cpu_rst_n, periph_rst_n, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0]  med_clk_en;
    logic [15:0] periph_clk_en;
    logic [12:0] probes;
    int          err_total, compares, tally, k;

    assign probes = {med_clk_en, cpu_clk_en, wdt_b_clk_en, tmr_a_clk_en, periph_clk_en[8],
                     periph_clk_en[1], periph_clk_en[0], bus_clk_en, sys_clk_en};
    always #25 pclk = ~pclk;

    cpg_top cpg_top_inst (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .subclock_pin, .hw_standby_n_pin, .wake_pin, .duty_corr_en, .osc_run,
        .sys_clk_en, .med_clk_en, .bus_clk_en, .cpu_clk_en, .periph_clk_en, .tmr_a_clk_en,
        .tmr_b_clk_en, .wdt_a_clk_en, .wdt_b_clk_en, .cpu_rst_n, .periph_rst_n);
    cpg_subclk_src cpg_subclk_src_inst (.pclk(pclk), .en(sub_en), .subclk(subclock_pin));

    task automatic wrap_up();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // ------------------------------------------------------------------------
    // APB master and helpers
    // ------------------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_total++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), rd, exp);
    endtask
    task automatic req(input logic [2:0] m);
        apb(1'b1, `CPG_OFF_MODE, {29'h0, m});
    endtask
    task automatic wait_mode(input logic [6:0] m);
        int n;
        n = 0;
        do begin
            apb(1'b0, `CPG_OFF_STAT, 32'h0);
            n++;
        end while (rd[6:0] !== m && n < 40);
        chk("mode", {25'h0, rd[6:0]}, {25'h0, m});
        if (rd[6:0] !== m)
            wrap_up();
    endtask
    task automatic wake(input logic [6:0] m);
        @(posedge pclk);
        wake_pin <= 1'b1;
        wait_mode(m);
        wake_pin <= 1'b0;
    endtask
    task automatic cnt(input int idx, input int n, input int exp);
        tally = 0;
        repeat (n) begin
            @(posedge pclk);
            tally += probes[idx];
        end
        chk($sformatf("ticks %0d", idx), tally, exp);
    endtask

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        hw_standby_n_pin = 1'b1;
        wake_pin = 1'b0;
        sub_en = 1'b0;
        err_total = 0;
        compares = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`CPG_OFF_SBY, 32'h0);
        rdc(`CPG_OFF_LPW, 32'h0);
        rdc(`CPG_OFF_MSH, 32'h0);
        rdc(`CPG_OFF_STC, 32'h0);
        rdc(`CPG_OFF_STAT, 32'h401);
        chk("duty", duty_corr_en, 1'b1);
        for (k = 0; k < 5; k++)
            cnt(8 + k, 64, 64 >> (k + 1));
        for (k = 0; k < 6; k++) begin
            apb(1'b1, `CPG_OFF_SBY, k);
            repeat (40) @(posedge pclk);
            cnt(1, 64, 64 >> k);
        end
        rdc(`CPG_OFF_STAT, 32'h681);
        apb(1'b1, `CPG_OFF_SBY, 32'hfe);
        rdc(`CPG_OFF_SBY, 32'hf6);
        repeat (40) @(posedge pclk);
        cnt(1, 64, 2);
        req(`CPG_REQ_SUBACT);
        wait_mode(CPG_RUN);
        apb(1'b1, `CPG_OFF_STC, 32'h08);
        apb(1'b1, `CPG_OFF_SBY, 32'h0);
        chk("lock err", err, 1'b1);
        rdc(`CPG_OFF_SBY, 32'h0);
        apb(1'b1, `CPG_OFF_STC, 32'h0);
        rdc(`CPG_OFF_SBY, 32'hf6);
        apb(1'b1, `CPG_OFF_SBY, 32'h0);
        rdc(`CPG_OFF_SBY, 32'h0);
        apb(1'b0, 8'h1c, 32'h0);
        chk("unmapped err", err, 1'b1);
        apb(1'b1, `CPG_OFF_MSL, 32'h1);
        apb(1'b1, `CPG_OFF_MSH, 32'h1);
        cnt(2, 16, 0);
        cnt(3, 16, 16);
        cnt(4, 16, 0);
        apb(1'b1, `CPG_OFF_MSL, 32'h0);
        apb(1'b1, `CPG_OFF_MSH, 32'h0);
        req(`CPG_REQ_SLEEP);
        wait_mode(CPG_SLEEP);
        cnt(7, 16, 0);
        cnt(3, 16, 16);
        wake(CPG_RUN);
        req(`CPG_REQ_SWSTBY);
        wait_mode(CPG_SWSTBY);
        chk("osc", osc_run, 1'b0);
        cnt(0, 16, 0);
        wake(CPG_RUN);
        @(posedge pclk);
        hw_standby_n_pin <= 1'b0;
        repeat (6) @(posedge pclk);
        chk("resets", {cpu_rst_n, periph_rst_n, osc_run}, 3'b000);
        hw_standby_n_pin <= 1'b1;
        wait_mode(CPG_RUN);
        apb(1'b1, `CPG_OFF_LPW, 32'hc0);
        rdc(`CPG_OFF_LPW, 32'hc0);
        sub_en <= 1'b1;
        repeat (1300) @(posedge pclk);
        apb(1'b1, `CPG_OFF_SBY, 32'h1);
        req(`CPG_REQ_SUBACT);
        wait_mode(CPG_RUN);
        apb(1'b1, `CPG_OFF_SBY, 32'h0);
        req(`CPG_REQ_SUBACT);
        wait_mode(CPG_SUBACT);
        cnt(0, 1220, 2);
        cnt(5, 1220, 2);
        cnt(3, 1220, 0);
        req(`CPG_REQ_SUBSLEEP);
        wait_mode(CPG_SUBSLEEP);
        cnt(7, 1220, 0);
        cnt(5, 1220, 2);
        wake(CPG_SUBACT);
        req(`CPG_REQ_WATCH);
        wait_mode(CPG_WATCH);
        cnt(5, 1220, 0);
        cnt(6, 1220, 2);
        wake(CPG_RUN);
        apb(1'b1, `CPG_OFF_LPW, 32'h0);
        sub_en <= 1'b0;
        cnt(0, 64, 64);
        wrap_up();
    end
endmodule
